// File: rtl/hpc_pkg.sv
//----------------------------------------------------------------------
// Package
//----------------------------------------------------------------------
// Purpose: Constants and types for the host port control logic
// Assumes: 25 MHz system clock
// Notes:   CPU offsets are byte addresses
package hpc_pkg;

	// CPU-side register offsets
	localparam logic [7:0]  HPC_OFS_CTRL   = 8'h30;
	localparam logic [7:0]  HPC_OFS_ADDR_W = 8'h34;
	localparam logic [7:0]  HPC_OFS_ADDR_R = 8'h38;

	// Control register field positions
	localparam int          HPC_BIT_ORDER  = 0;
	localparam int          HPC_BIT_H2C    = 1;
	localparam int          HPC_BIT_C2H    = 2;
	localparam int          HPC_BIT_RDY    = 3;
	localparam int          HPC_BIT_FETCH  = 4;
	localparam int          HPC_BIT_SRST   = 7;
	localparam int          HPC_BIT_OSTAT  = 8;
	localparam int          HPC_BIT_DUAL   = 9;
	localparam int          HPC_BIT_ARWSEL = 11;

	// Reset values
	localparam logic [31:0] HPC_ADDR_RST   = 32'h0000_0000;
	localparam logic [31:0] HPC_ZERO_WORD  = 32'h0000_0000;
	localparam logic [15:0] HPC_ZERO_HALF  = 16'h0000;

	// FIFO flush pulse length
	localparam int          HPC_CLK_NS     = 40;
	localparam int          HPC_FLUSH_NS   = 160;
	localparam int          HPC_FLUSH_CYC  = (HPC_FLUSH_NS + HPC_CLK_NS - 1) / HPC_CLK_NS;
	localparam logic [2:0]  HPC_FLUSH_LAST = 3'(HPC_FLUSH_CYC - 1);

	typedef enum logic [1:0] {
		HPC_CYC_CTRL = 2'h0,
		HPC_CYC_ADDR = 2'h1,
		HPC_CYC_DATA = 2'h2
	} hpc_cyc_t;

	typedef enum logic [1:0] {
		HPC_SR_IDLE  = 2'h0,
		HPC_SR_WAIT  = 2'h1,
		HPC_SR_FLUSH = 2'h2,
		HPC_SR_HOLD  = 2'h3
	} hpc_srst_t;

	typedef struct packed {
		logic        stb;
		hpc_cyc_t    cyc;
		logic        rd;
		logic        second;
		logic [15:0] wdata;
	} hpc_host_req_t;

	typedef struct packed {
		logic        sel;
		logic        wr;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} hpc_cpu_req_t;

endpackage

// File: rtl/hpc_port_control.sv
// Purpose: Control/status bits and address registers of the host port
// Assumes: All inputs synchronous to i_clk_sys; host honours o_port_ready
// Notes:   Host side moves 16-bit halfwords, two per 32-bit host cycle
//
// Summary of operation
// [RULE1] Single address mode: host address write loads read and write address alike.
// [RULE2] Single address mode: each autoincrement advances both address registers.
// [RULE3] Single address mode: host address read returns the read address register.
// [RULE4] Dual address mode: separate read and write address registers seen by host.
// [RULE5] Bit 8 always mirrors the halfword order setting.
// [RULE6] Host reads of soft reset bit always return zero.
// [RULE7] After CPU sets soft reset, CPU reads zero until FIFO reset completes.
// [RULE8] CPU writing zero before reset completes does not abort it.
// [RULE9] CPU writing one to soft reset resets both FIFOs and their control.
// [RULE10] An active host cycle finishes before the FIFO reset begins.
// [RULE11] Ready output held not-ready while soft reset bit is one.
// [RULE12] CPU must write zero to soft reset to resume host accesses.
// [RULE13] Reserved bits 6-5 written zero by host, kept zero against CPU.
// [RULE14] Prefetch command bit always reads zero for host and CPU.
// [RULE15] Host writing one to prefetch bit starts a fetch into read FIFO.
// [RULE16] Host read of ready flag shows internal ready state.
// [RULE17] CPU reads of ready flag always return zero.
// [RULE18] Ready flag comes from internal ready, not from the ready pin.
// [RULE19] CPU writing one raises CPU-to-host interrupt; held until host clears.
// [RULE20] Host writing one to CPU-to-host interrupt bit clears it.
// [RULE21] Writing zero to CPU-to-host interrupt bit changes nothing.
// [RULE22] Host-to-CPU flag: host sets it, only CPU clears it.
// [RULE23] Host writing one raises host-to-CPU interrupt; held until CPU clears.
// [RULE24] CPU writing one clears host-to-CPU flag; zero writes do nothing.
// [RULE25] Order zero: first halfword most significant; one: least significant.
// [RULE26] Simultaneous set and clear of an interrupt flag: set wins.
`timescale 1ns/100ps
module hpc_port_control (
	input  wire logic                  i_clk_sys,    // System clock
	input  wire logic                  i_rst_b,      // Sync reset, active low
	input  wire logic                  i_boot_sel,   // Host boot strap
	input  wire hpc_pkg::hpc_host_req_t i_host_req,  // Host halfword request
	output logic [15:0]                o_host_rdata, // Host read halfword
	output logic                       o_port_ready, // Ready pin level
	output logic                       o_host_irq,   // CPU-to-host interrupt
	input  wire hpc_pkg::hpc_cpu_req_t i_cpu_req,    // CPU register request
	output logic [31:0]                o_cpu_rdata,  // CPU read data
	output logic                       o_cpu_irq,    // Host-to-CPU interrupt
	input  wire logic                  i_dp_ready,   // Datapath ready
	input  wire logic                  i_dp_busy,    // Datapath cycle active
	input  wire logic [31:0]           i_dp_rdata,   // Read FIFO head word
	input  wire logic                  i_inc_rd,     // Read address step
	input  wire logic                  i_inc_wr,     // Write address step
	output logic                       o_dp_rd,      // Pop read FIFO
	output logic                       o_dp_wr,      // Push write FIFO
	output logic [31:0]                o_dp_wdata,   // Write FIFO word
	output logic                       o_fetch,      // Prefetch start pulse
	output logic                       o_fifo_rst,   // FIFO reset level
	output logic [31:0]                o_addr_rd,    // Read address
	output logic [31:0]                o_addr_wr     // Write address
);
	import hpc_pkg::*;

	//----------------------------------------------------------------------
	// State
	//----------------------------------------------------------------------
	logic        dual_mode;
	logic        arwsel;
	logic        hw_order;
	logic        srst_bit;
	hpc_srst_t   srst_st;
	logic [2:0]  flush_cnt;
	logic        first_seen;
	logic [15:0] hold_half;
	logic [31:0] rd_word;
	logic        int_rdy;
	logic        host_busy;
	logic        host_acc;
	logic        host_wr_done;
	logic        host_rd_first;
	logic [31:0] host_word;
	logic [31:0] host_ctrl_word;
	logic [31:0] cpu_ctrl_word;
	logic        cpu_ctrl_wr;
	logic        host_ctrl_wr;
	logic        host_addr_wr;
	logic        c2h_set;
	logic        c2h_clr;
	logic        h2c_set;
	logic        h2c_clr;
	hpc_srst_t   next_srst_st;

	// Picks the half of a word that goes out first or second
	function automatic logic [15:0] pick_half(input logic [31:0] w, input logic low);
		pick_half = low ? w[15:0] : w[31:16];
	endfunction

	//----------------------------------------------------------------------
	// Host access decode
	//----------------------------------------------------------------------
	assign host_acc      = i_host_req.stb && (srst_st != HPC_SR_FLUSH)
		&& (srst_st != HPC_SR_HOLD);
	assign host_wr_done  = host_acc && !i_host_req.rd && i_host_req.second && first_seen;
	assign host_rd_first = host_acc && i_host_req.rd && !i_host_req.second;
	assign host_ctrl_wr  = host_wr_done && (i_host_req.cyc == HPC_CYC_CTRL);
	assign host_addr_wr  = host_wr_done && (i_host_req.cyc == HPC_CYC_ADDR);
	assign host_busy     = first_seen || i_dp_busy;
	assign cpu_ctrl_wr   = i_cpu_req.sel && i_cpu_req.wr && (i_cpu_req.addr == HPC_OFS_CTRL);

	// Assembled host word
	always_comb begin
		if (hw_order) begin
			host_word = {i_host_req.wdata, hold_half};                // [RULE25]
		end else begin
			host_word = {hold_half, i_host_req.wdata};                // [RULE25]
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			first_seen <= 1'b0;
			hold_half  <= HPC_ZERO_HALF;
		end else if (host_acc && !i_host_req.second) begin
			first_seen <= 1'b1;
			hold_half  <= i_host_req.wdata;
		end else if (host_acc) begin
			first_seen <= 1'b0;
		end
	end

	//----------------------------------------------------------------------
	// Host-owned configuration
	//----------------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			dual_mode <= 1'b0;
			arwsel    <= 1'b0;
			hw_order  <= 1'b0;
		end else if (host_ctrl_wr) begin
			dual_mode <= host_word[HPC_BIT_DUAL];
			arwsel    <= host_word[HPC_BIT_ARWSEL];
			hw_order  <= host_word[HPC_BIT_ORDER];
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			o_fetch <= 1'b0;
		end else begin
			o_fetch <= host_ctrl_wr && host_word[HPC_BIT_FETCH];      // [RULE15]
		end
	end

	//----------------------------------------------------------------------
	// Address registers
	//----------------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			o_addr_rd <= HPC_ADDR_RST;
		end else if (host_addr_wr && (!dual_mode || arwsel)) begin
			o_addr_rd <= host_word;                                   // [RULE1] [RULE4]
		end else if (i_inc_rd || (!dual_mode && i_inc_wr)) begin
			o_addr_rd <= o_addr_rd + 32'h0000_0001;                   // [RULE2]
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			o_addr_wr <= HPC_ADDR_RST;
		end else if (host_addr_wr && (!dual_mode || !arwsel)) begin
			o_addr_wr <= host_word;                                   // [RULE1] [RULE4]
		end else if (i_inc_wr || (!dual_mode && i_inc_rd)) begin
			o_addr_wr <= o_addr_wr + 32'h0000_0001;                   // [RULE2]
		end
	end

	//----------------------------------------------------------------------
	// Soft reset sequence
	//----------------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			srst_bit <= !i_boot_sel;
		end else if (cpu_ctrl_wr && i_cpu_req.wdata[HPC_BIT_SRST]) begin
			srst_bit <= 1'b1;
		end else if (cpu_ctrl_wr && (srst_st == HPC_SR_HOLD)) begin
			srst_bit <= 1'b0;                                         // [RULE8] [RULE12]
		end
	end

	always_comb begin
		next_srst_st = srst_st;
		unique case (srst_st)
			HPC_SR_IDLE: begin
				if (srst_bit) begin
					next_srst_st = HPC_SR_WAIT;
				end
			end
			HPC_SR_WAIT: begin
				if (!host_busy) begin
					next_srst_st = HPC_SR_FLUSH;                          // [RULE10]
				end
			end
			HPC_SR_FLUSH: begin
				if (flush_cnt == HPC_FLUSH_LAST) begin
					next_srst_st = HPC_SR_HOLD;
				end
			end
			HPC_SR_HOLD: begin
				if (!srst_bit) begin
					next_srst_st = HPC_SR_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			srst_st <= i_boot_sel ? HPC_SR_IDLE : HPC_SR_WAIT;
		end else begin
			srst_st <= next_srst_st;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b || (srst_st != HPC_SR_FLUSH)) begin
			flush_cnt <= 3'h0;
		end else begin
			flush_cnt <= flush_cnt + 3'h1;
		end
	end

	assign o_fifo_rst = (srst_st == HPC_SR_FLUSH);                    // [RULE9]

	//----------------------------------------------------------------------
	// Ready
	//----------------------------------------------------------------------
	assign int_rdy      = i_dp_ready && (srst_st == HPC_SR_IDLE);
	assign o_port_ready = int_rdy && !srst_bit;                       // [RULE11]

	//----------------------------------------------------------------------
	// Interrupt flags
	//----------------------------------------------------------------------
	assign c2h_set = cpu_ctrl_wr && i_cpu_req.wdata[HPC_BIT_C2H];     // [RULE19]
	assign c2h_clr = host_ctrl_wr && host_word[HPC_BIT_C2H];          // [RULE20] [RULE21]
	assign h2c_set = host_ctrl_wr && host_word[HPC_BIT_H2C];          // [RULE22] [RULE23]
	assign h2c_clr = cpu_ctrl_wr && i_cpu_req.wdata[HPC_BIT_H2C];     // [RULE24]

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			o_host_irq <= 1'b0;
		end else if (c2h_set) begin
			o_host_irq <= 1'b1;                                       // [RULE26]
		end else if (c2h_clr) begin
			o_host_irq <= 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			o_cpu_irq <= 1'b0;
		end else if (h2c_set) begin
			o_cpu_irq <= 1'b1;                                        // [RULE26]
		end else if (h2c_clr) begin
			o_cpu_irq <= 1'b0;
		end
	end

	//----------------------------------------------------------------------
	// Read views of the control register
	//----------------------------------------------------------------------
	always_comb begin
		host_ctrl_word                 = HPC_ZERO_WORD;               // [RULE13] [RULE14] [RULE6]
		host_ctrl_word[HPC_BIT_ARWSEL] = arwsel;
		host_ctrl_word[HPC_BIT_DUAL]   = dual_mode;
		host_ctrl_word[HPC_BIT_OSTAT]  = hw_order;                    // [RULE5]
		host_ctrl_word[HPC_BIT_RDY]    = int_rdy;                     // [RULE16] [RULE18]
		host_ctrl_word[HPC_BIT_C2H]    = o_host_irq;
		host_ctrl_word[HPC_BIT_H2C]    = o_cpu_irq;
		host_ctrl_word[HPC_BIT_ORDER]  = hw_order;
		host_ctrl_word[31:16]          = host_ctrl_word[15:0];
	end

	always_comb begin
		cpu_ctrl_word                = host_ctrl_word;
		cpu_ctrl_word[31:16]         = HPC_ZERO_HALF;
		cpu_ctrl_word[HPC_BIT_RDY]   = 1'b0;                          // [RULE17]
		cpu_ctrl_word[HPC_BIT_SRST]  = srst_bit && (srst_st == HPC_SR_HOLD); // [RULE7]
	end

	//----------------------------------------------------------------------
	// Host read path and datapath strobes
	//----------------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			rd_word      <= HPC_ZERO_WORD;
			o_host_rdata <= HPC_ZERO_HALF;
		end else if (host_rd_first) begin
			unique case (i_host_req.cyc)
				HPC_CYC_CTRL: begin
					rd_word      <= host_ctrl_word;
					o_host_rdata <= pick_half(host_ctrl_word, hw_order);
				end
				HPC_CYC_ADDR: begin
					rd_word      <= (dual_mode && !arwsel) ? o_addr_wr : o_addr_rd; // [RULE3]
					o_host_rdata <= pick_half((dual_mode && !arwsel) ? o_addr_wr : o_addr_rd,
						hw_order);
				end
				HPC_CYC_DATA: begin
					rd_word      <= i_dp_rdata;
					o_host_rdata <= pick_half(i_dp_rdata, hw_order);  // [RULE25]
				end
				default: begin
					rd_word      <= HPC_ZERO_WORD;
					o_host_rdata <= HPC_ZERO_HALF;
				end
			endcase
		end else if (host_acc && i_host_req.rd) begin
			o_host_rdata <= pick_half(rd_word, !hw_order);
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			o_dp_rd    <= 1'b0;
			o_dp_wr    <= 1'b0;
			o_dp_wdata <= HPC_ZERO_WORD;
		end else begin
			o_dp_rd <= host_rd_first && (i_host_req.cyc == HPC_CYC_DATA);
			o_dp_wr <= host_wr_done && (i_host_req.cyc == HPC_CYC_DATA);
			if (host_wr_done) begin
				o_dp_wdata <= host_word;
			end
		end
	end

	//----------------------------------------------------------------------
	// CPU read port
	//----------------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			o_cpu_rdata <= HPC_ZERO_WORD;
		end else if (i_cpu_req.sel && !i_cpu_req.wr) begin
			unique case (i_cpu_req.addr)
				HPC_OFS_CTRL:   o_cpu_rdata <= cpu_ctrl_word;
				HPC_OFS_ADDR_W: o_cpu_rdata <= o_addr_wr;
				HPC_OFS_ADDR_R: o_cpu_rdata <= o_addr_rd;
				default:        o_cpu_rdata <= HPC_ZERO_WORD;
			endcase
		end
	end

	//----------------------------------------------------------------------
	// Assertions
	//----------------------------------------------------------------------
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);

	a_single_addr_load: assert property (host_addr_wr && !dual_mode |=> // [RULE1]
		(o_addr_rd == $past(host_word)) && (o_addr_wr == $past(host_word)))
		else $error("single mode address write did not load both registers");
	a_single_incr_both: assert property (!dual_mode && !host_addr_wr && i_inc_wr |=> // [RULE2]
		(o_addr_rd == $past(o_addr_rd) + 32'h1) && (o_addr_wr == $past(o_addr_wr) + 32'h1))
		else $error("single mode step did not advance both registers");
	a_host_srst_zero: assert property (host_ctrl_word[HPC_BIT_SRST] == 1'b0 // [RULE6]
		&& host_ctrl_word[HPC_BIT_FETCH] == 1'b0)
		else $error("host view shows soft reset or prefetch bit");
	a_cpu_srst_hidden: assert property ((srst_st != HPC_SR_HOLD) |-> // [RULE7]
		!cpu_ctrl_word[HPC_BIT_SRST])
		else $error("CPU saw soft reset bit before flush completed");
	a_srst_no_abort: assert property ((srst_st == HPC_SR_FLUSH) |=> srst_bit) // [RULE8]
		else $error("soft reset cleared during flush");
	a_flush_length: assert property ($rose(o_fifo_rst) |-> o_fifo_rst[*4] ##1 !o_fifo_rst) // [RULE9]
		else $error("FIFO reset pulse has wrong length");
	a_wait_host: assert property ((srst_st == HPC_SR_WAIT) && host_busy |=> // [RULE10]
		!o_fifo_rst)
		else $error("flush started during a host cycle");
	a_ready_held: assert property (srst_bit |-> !o_port_ready) // [RULE11]
		else $error("ready pin asserted while soft reset bit set");
	a_cpu_rdy_zero: assert property (cpu_ctrl_word[HPC_BIT_RDY] == 1'b0 // [RULE17]
		&& cpu_ctrl_word[6:5] == 2'h0)
		else $error("CPU view shows ready flag or reserved bits");
	a_c2h_raise: assert property (c2h_set |=> o_host_irq) // [RULE19]
		else $error("CPU-to-host interrupt not raised");
	a_h2c_hold: assert property (o_cpu_irq && !h2c_clr |=> o_cpu_irq) // [RULE23]
		else $error("host-to-CPU interrupt dropped without CPU clear");

	c_flush_done: cover property ((srst_st == HPC_SR_FLUSH) ##1 (srst_st == HPC_SR_HOLD));
	c_dual_addr:  cover property (host_addr_wr && dual_mode);
	c_irq_race:   cover property (c2h_set && c2h_clr);
endmodule

// File: test/hpc_host_model.sv
// Purpose: Behavioural external host on the halfword host port
// Assumes: Tasks are entered just after a rising clock edge
// Notes:   Released write data is inverted so a stale value never matches
`timescale 1ns/100ps
module hpc_host_model (
	input  wire logic              i_clk_sys,  // System clock
	input  wire logic              i_ready,    // Ready pin level
	input  wire logic [15:0]       i_rdata,    // Read halfword
	output hpc_pkg::hpc_host_req_t o_req,      // Halfword request
	output logic [31:0]            o_word,     // Assembled read word
	output logic                   o_word_vld  // Read word strobe
);
	import hpc_pkg::*;
	logic order;
	initial begin
		order = 1'b0;
		o_req = '0;
		o_word = '0;
		o_word_vld = 1'b0;
	end
	task automatic xfer(input hpc_cyc_t cyc, input logic rd, input logic [31:0] w);
		logic [15:0] h [2];
		logic [15:0] g [2];
		int          n;
		n = 0;
		while (i_ready !== 1'b1 && n < 100) begin
			@(posedge i_clk_sys);
			#1;
			n++;
		end
		if (cyc == HPC_CYC_CTRL) w = w & ~32'h0000_0060;
		h[0] = order ? w[15:0] : w[31:16];
		h[1] = order ? w[31:16] : w[15:0];
		for (int k = 0; k < 2; k++) begin
			o_req = '{1'b1, cyc, rd, k[0], rd ? ~o_req.wdata : h[k]};
			@(posedge i_clk_sys);
			#1;
			g[k] = i_rdata;
		end
		o_req.stb = 1'b0;
		o_req.wdata = ~o_req.wdata;
		o_word = order ? {g[1], g[0]} : {g[0], g[1]};
		o_word_vld = rd;
		if (!rd && cyc == HPC_CYC_CTRL) order = w[0];
		@(posedge i_clk_sys);
		#1;
		o_word_vld = 1'b0;
	endtask
endmodule

// File: test/tb_top.sv
// Purpose: Self-checking bench for the host port control logic
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Read results are queued and checked by a monitor process
`timescale 1ns/100ps
module tb_top;
	import hpc_pkg::*;
	logic          i_clk_sys = 1'b0;
	logic          i_rst_b = 1'b0;
	logic          i_boot_sel = 1'b0;
	hpc_host_req_t i_host_req;
	hpc_cpu_req_t  i_cpu_req = '0;
	logic          i_dp_ready = 1'b1;
	logic          i_dp_busy = 1'b0;
	logic [31:0]   i_dp_rdata = '0;
	logic          i_inc_rd = 1'b0;
	logic          i_inc_wr = 1'b0;
	logic [15:0]   o_host_rdata;
	logic          o_port_ready, o_host_irq, o_cpu_irq, o_dp_rd, o_dp_wr, o_fetch, o_fifo_rst;
	logic [31:0]   o_cpu_rdata, o_dp_wdata, o_addr_rd, o_addr_wr, word, a, b;
	logic          word_vld;
	logic          cpu_vld = 1'b0;
	logic          sel = 0, dual = 0, ord = 0, c2h = 0, h2c = 0;
	int            errors = 0, comparisons = 0, fetch_n = 0, flush_n = 0, rd_n = 0, wr_n = 0;
	logic [31:0]   exp_q [$];
	always #20 i_clk_sys = ~i_clk_sys;
	hpc_port_control hpc_port_control_i (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
		.i_boot_sel(i_boot_sel), .i_host_req(i_host_req), .o_host_rdata(o_host_rdata),
		.o_port_ready(o_port_ready), .o_host_irq(o_host_irq), .i_cpu_req(i_cpu_req),
		.o_cpu_rdata(o_cpu_rdata), .o_cpu_irq(o_cpu_irq), .i_dp_ready(i_dp_ready),
		.i_dp_busy(i_dp_busy), .i_dp_rdata(i_dp_rdata), .i_inc_rd(i_inc_rd),
		.i_inc_wr(i_inc_wr), .o_dp_rd(o_dp_rd), .o_dp_wr(o_dp_wr), .o_dp_wdata(o_dp_wdata),
		.o_fetch(o_fetch), .o_fifo_rst(o_fifo_rst), .o_addr_rd(o_addr_rd), .o_addr_wr(o_addr_wr));
	hpc_host_model hpc_host_model_i (.i_clk_sys(i_clk_sys), .i_ready(o_port_ready),
		.i_rdata(o_host_rdata), .o_req(i_host_req), .o_word(word), .o_word_vld(word_vld));
	//------------------------------------------------------------------
	// Checking
	//------------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	always @(posedge i_clk_sys) begin
		if (i_rst_b === 1'b1 && o_fetch === 1'b1) fetch_n++;
		if (i_rst_b === 1'b1 && o_fifo_rst === 1'b1) flush_n++;
		if (i_rst_b === 1'b1 && o_dp_rd === 1'b1) rd_n++;
		if (i_rst_b === 1'b1 && o_dp_wr === 1'b1) wr_n++;
	end
	always @(negedge i_clk_sys) begin
		if (cpu_vld === 1'b1 || word_vld === 1'b1) begin
			if (exp_q.size() == 0) begin
				errors++;
				$display("[ERR] t=%0t got=%h exp=none", $time, o_cpu_rdata);
			end else begin
				chk(cpu_vld === 1'b1 ? o_cpu_rdata : word, exp_q.pop_front());
			end
		end
	end
	function automatic logic [31:0] view(input logic host, input logic rdy);
		logic [15:0] lo;
		lo = {4'h0, sel, 1'b0, dual, ord, 4'h0, host & rdy, c2h, h2c, ord};
		return host ? {lo, lo} : {16'h0, lo};
	endfunction
	//------------------------------------------------------------------
	// Drivers
	//------------------------------------------------------------------
	task automatic cpu(input logic wr, input logic [7:0] ad, input logic [31:0] d);
		i_cpu_req = '{1'b1, wr, ad, d};
		@(posedge i_clk_sys);
		#1;
		i_cpu_req = '{1'b0, wr, ~ad, ~d};
		cpu_vld = ~wr;
		@(posedge i_clk_sys);
		#1;
		cpu_vld = 1'b0;
	endtask
	task automatic cpu_rd(input logic [7:0] ad, input logic [31:0] e);
		exp_q.push_back(e);
		cpu(1'b0, ad, '0);
	endtask
	task automatic hrd(input hpc_cyc_t cyc, input logic [31:0] e);
		exp_q.push_back(e);
		hpc_host_model_i.xfer(cyc, 1'b1, '0);
	endtask
	task automatic hctl(input logic s, input logic d, input logic o, input logic [2:0] fch);
		sel = s;
		dual = d;
		ord = o;
		// Fetch on bit 4, CPU-to-host on bit 2, host-to-CPU on bit 1
		hpc_host_model_i.xfer(HPC_CYC_CTRL, 1'b0,
			{20'h0, s, 1'b0, d, 4'h0, fch[2], 1'b0, fch[1:0], o});
	endtask
	task automatic report_and_stop();
		if (exp_q.size() != 0) errors++;
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		#300000;
		errors++;
		report_and_stop();
	end
	//------------------------------------------------------------------
	// Tests
	//------------------------------------------------------------------
	initial begin
		void'($urandom(32'hcb6db5a8));
		repeat (3) @(posedge i_clk_sys);
		#1;
		i_rst_b = 1'b1;
		chk(o_port_ready, 0);
		repeat (8) @(posedge i_clk_sys);
		#1;
		chk(flush_n, 4);
		cpu_rd(HPC_OFS_CTRL, 32'h80);
		cpu(1'b1, HPC_OFS_CTRL, 32'h0);
		chk(o_port_ready, 1);
		hctl(0, 0, 0, 3'b001);
		h2c = 1;
		chk(o_cpu_irq, 1);
		hrd(HPC_CYC_CTRL, view(1, 1));
		cpu_rd(HPC_OFS_CTRL, view(0, 1));
		cpu(1'b1, HPC_OFS_CTRL, 32'h0);
		chk(o_cpu_irq, 1);
		cpu(1'b1, HPC_OFS_CTRL, 32'h2);
		h2c = 0;
		chk(o_cpu_irq, 0);
		cpu(1'b1, HPC_OFS_CTRL, 32'h4);
		c2h = 1;
		chk(o_host_irq, 1);
		hctl(0, 0, 0, 3'b100);
		chk(o_host_irq, 1);
		hrd(HPC_CYC_CTRL, view(1, 1));
		hctl(0, 0, 0, 3'b010);
		c2h = 0;
		chk(o_host_irq, 0);
		repeat (2) @(posedge i_clk_sys);
		#1;
		chk(fetch_n, 1);
		cpu(1'b1, HPC_OFS_CTRL, 32'hffff_ff60);
		cpu_rd(HPC_OFS_CTRL, view(0, 1));
		cpu_rd(8'h3c, 32'h0);
		for (int k = 0; k < 2; k++) begin
			hctl(0, 0, k[0], 3'b000);
			a = $urandom;
			hpc_host_model_i.xfer(HPC_CYC_ADDR, 1'b0, a);
			chk(o_addr_rd, a);
			chk(o_addr_wr, a);
			i_inc_rd = ~k[0];
			i_inc_wr = k[0];
			@(posedge i_clk_sys);
			#1;
			i_inc_rd = 1'b0;
			i_inc_wr = 1'b0;
			@(posedge i_clk_sys);
			#1;
			chk(o_addr_rd, a + 1);
			chk(o_addr_wr, a + 1);
			cpu_rd(HPC_OFS_ADDR_W, a + 1);
			i_dp_rdata = $urandom;
			hrd(HPC_CYC_DATA, i_dp_rdata);
			b = $urandom;
			hpc_host_model_i.xfer(HPC_CYC_DATA, 1'b0, b);
			chk(o_dp_wdata, b);
		end
		chk(rd_n, 2);
		chk(wr_n, 2);
		hctl(1, 1, 1, 3'b000);
		b = $urandom;
		hpc_host_model_i.xfer(HPC_CYC_ADDR, 1'b0, b);
		chk(o_addr_rd, b);
		chk(o_addr_wr, a + 1);
		hctl(0, 1, 1, 3'b000);
		hrd(HPC_CYC_ADDR, a + 1);
		hctl(0, 0, 0, 3'b000);
		hrd(HPC_CYC_ADDR, b);
		fork
			hctl(0, 0, 0, 3'b001);
			begin
				@(posedge i_clk_sys);
				#1;
				cpu(1'b1, HPC_OFS_CTRL, 32'h2);
			end
		join
		h2c = 1;
		chk(o_cpu_irq, 1);
		i_dp_busy = 1'b1;
		cpu(1'b1, HPC_OFS_CTRL, 32'h80);
		chk(o_port_ready, 0);
		chk(flush_n, 4);
		cpu_rd(HPC_OFS_CTRL, view(0, 1));
		i_dp_busy = 1'b0;
		cpu(1'b1, HPC_OFS_CTRL, 32'h0);
		repeat (6) @(posedge i_clk_sys);
		#1;
		chk(flush_n, 8);
		chk(o_port_ready, 0);
		cpu(1'b1, HPC_OFS_CTRL, 32'h0);
		chk(o_port_ready, 1);
		// Second reset with host boot strap: no flush, interrupts cleared
		i_boot_sel = 1'b1;
		i_rst_b = 1'b0;
		repeat (3) @(posedge i_clk_sys);
		#1;
		i_rst_b = 1'b1;
		h2c = 0;
		chk(o_cpu_irq, 0);
		chk(o_port_ready, 1);
		hrd(HPC_CYC_CTRL, view(1, 1));
		chk(flush_n, 8);
		repeat (2) @(posedge i_clk_sys);
		report_and_stop();
	end
endmodule
